//--- logic/tpe_pkg.sv
// Purpose: shared constants and carriers for the translation cache parity error injector
// Assumes: APB register access with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses within the unit's register page
package tpe_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [19:0] OFS_FAULT_CONTROL = 20'h08E88;
	localparam logic [19:0] OFS_FAULT_STATUS = 20'h08E90;
	localparam logic [19:0] OFS_IRQ_MASK = 20'h08EA0;
	localparam logic [19:0] OFS_INJECTION = 20'h08EC0;
	localparam int ADDR_W = 20;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_INJECT_DATA = 0;
	localparam int BIT_INJECT_TAG = 1;
	localparam int BIT_FAULT_IRQ_EN = 3;
	localparam int BIT_EVT_TAG = 0;
	localparam int BIT_EVT_DATA = 1;
	localparam int SYN_LSB = 8;
	localparam logic [31:0] RST_INJECTION = 32'h0000_0000;
	localparam logic [31:0] RST_FAULT_CONTROL = 32'h0000_0008;
	localparam logic [1:0] RST_IRQ_MASK = 2'h3;
	localparam logic [7:0] SYN_NONE = 8'h00;
	localparam logic [7:0] SYN_TAG = 8'h07;
	localparam logic [7:0] SYN_DATA = 8'h08;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} tpe_apb_req_s;

	typedef struct packed {
		logic valid;
		logic tagPar;
		logic dataPar;
	} tpe_parity_s;
endpackage

//--- logic/tpe_injector.sv
// Purpose: parity error injection into a main translation cache, with fault reporting
// Assumes: one clock, synchronous active-high reset; APB slave answers with no wait state
// Notes: the cache model holds only parity-relevant state: valid, tag parity and data parity
//
// Operation
// [RL1] tag-inject bit set: every cache write stores a wrong tag parity
// [RL2] tag-inject bit clear: cache writes store correct tag parity
// [RL3] data-inject bit set: every cache write stores a wrong data parity
// [RL4] data-inject bit clear: cache writes store correct data parity
// [RL5] fault raised when a corrupted entry is looked up, never on write
// [RL6] tag fault hides data fault when both are present
// [RL7] software should not set both inject bits when testing data faults
// [RL8] one clock and one reset drive the whole unit
// [RL9] syndrome code 0x07 for tag corruption, 0x08 for data corruption
// [RL10] fault interrupt enable routes parity faults onto the interrupt output
// [RL11] injection register at 0x08EC0, resets to zero
// [RL12] injection applies only to writes made while the bit is set
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tpe_injector #(
	parameter int ENTRIES = 16,
	parameter int TAG_W = 20,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tpe_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cache fill port
	input wire logic fillValid,
	input wire logic [$clog2(ENTRIES)-1:0] fillIndex,
	input wire logic [TAG_W-1:0] fillTag,
	input wire logic [DATA_W-1:0] fillData,
	// cache lookup port
	input wire logic lookupValid,
	input wire logic [$clog2(ENTRIES)-1:0] lookupIndex,
	input wire logic [TAG_W-1:0] lookupTag,
	input wire logic [DATA_W-1:0] lookupData,
	// lookup result and fault reporting
	output logic lookupHit,
	output logic faultTag,
	output logic faultData,
	output logic faultIrq
);
	import tpe_pkg::*;

	initial begin
		if (ENTRIES < 2 || TAG_W < 1 || DATA_W < 1) begin
			$error("tpe_injector: unsupported parameter values");
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [1:0] inject_r;
	logic faultIrqEn_r;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic [7:0] syndrome_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic lookupHit_r;
	logic faultTag_r;
	logic faultData_r;
	logic faultIrq_r;
	tpe_parity_s entry_r [ENTRIES];

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire setupPhase = psel && !penable;
	wire wrStrobe = psel && penable && pwrite && pready_r;
	wire hitInject = (paddr == OFS_INJECTION);
	wire hitControl = (paddr == OFS_FAULT_CONTROL);
	wire hitStatus = (paddr == OFS_FAULT_STATUS);
	wire hitMask = (paddr == OFS_IRQ_MASK);
	wire hitAny = hitInject || hitControl || hitStatus || hitMask;
	wire [31:0] rdMux = hitInject ? {30'h0, inject_r} :
		hitControl ? (32'h0 | (32'(faultIrqEn_r) << BIT_FAULT_IRQ_EN)) :
		hitStatus ? {22'h0, status_r, syndrome_r} :
		hitMask ? {30'h0, mask_r} : 32'h0;

	// ----------------------------------------------------------------
	// parity and lookup
	// ----------------------------------------------------------------
	// stored parity is the true parity xor the inject bit sampled at the write
	wire fillTagPar = ^fillTag ^ inject_r[BIT_INJECT_TAG]; // RL1 RL2 RL12
	wire fillDataPar = ^fillData ^ inject_r[BIT_INJECT_DATA]; // RL3 RL4 RL12
	tpe_parity_s lookEntry;
	assign lookEntry = entry_r[lookupIndex];
	// check happens only on use, so a corrupted entry costs nothing until read
	wire useValid = lookupValid && lookEntry.valid; // RL5
	wire tagBad = useValid && (lookEntry.tagPar != ^lookupTag); // RL5
	wire dataBad = useValid && !tagBad && (lookEntry.dataPar != ^lookupData); // RL6
	wire [1:0] evt = {dataBad, tagBad};
	wire [1:0] clrBits = (wrStrobe && hitStatus) ? pwdata[SYN_LSB+1:SYN_LSB] : 2'h0;
	wire [1:0] statusNxt = (status_r & ~clrBits) | evt;
	wire irqNxt = faultIrqEn_r && |(statusNxt & mask_r); // RL10

	// ----------------------------------------------------------------
	// register writes, single clock domain
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin // RL8
		if (sys_rst) begin
			inject_r <= RST_INJECTION[1:0]; // RL11
			faultIrqEn_r <= RST_FAULT_CONTROL[BIT_FAULT_IRQ_EN];
			mask_r <= RST_IRQ_MASK;
		end else if (wrStrobe) begin
			if (hitInject) begin
				inject_r <= pwdata[1:0]; // RL11
			end
			if (hitControl) begin
				faultIrqEn_r <= pwdata[BIT_FAULT_IRQ_EN];
			end
			if (hitMask) begin
				mask_r <= pwdata[1:0];
			end
		end
	end

	// status: set wins over write-one-to-clear; syndrome keeps the earliest error
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_r <= 2'h0;
			syndrome_r <= SYN_NONE;
		end else begin
			status_r <= statusNxt;
			if (status_r == 2'h0 || statusNxt == 2'h0) begin
				syndrome_r <= tagBad ? SYN_TAG : (dataBad ? SYN_DATA : SYN_NONE); // RL9
			end
		end
	end

	// apb answer: one wait-free access phase, error on unmapped address
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= setupPhase;
			pslverr_r <= setupPhase && !hitAny;
			prdata_r <= (setupPhase && !pwrite) ? rdMux : 32'h0;
		end
	end

	// cache entries: a fill fixes parity once; later bit changes do not touch it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < ENTRIES; i++) begin
				entry_r[i] <= '0;
			end
		end else if (fillValid) begin
			entry_r[fillIndex] <= '{valid: 1'b1, tagPar: fillTagPar, dataPar: fillDataPar}; // RL12
		end
	end

	// lookup result and fault pulses, registered
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lookupHit_r <= 1'b0;
			faultTag_r <= 1'b0;
			faultData_r <= 1'b0;
			faultIrq_r <= 1'b0;
		end else begin
			lookupHit_r <= useValid && !tagBad && !dataBad;
			faultTag_r <= tagBad; // RL5
			faultData_r <= dataBad; // RL6
			faultIrq_r <= irqNxt; // RL10
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign lookupHit = lookupHit_r;
	assign faultTag = faultTag_r;
	assign faultData = faultData_r;
	assign faultIrq = faultIrq_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_tag_inject;
		@(posedge sys_clk) disable iff (sys_rst)
		fillValid |=> (entry_r[$past(fillIndex)].tagPar == (^$past(fillTag) ^ $past(inject_r[BIT_INJECT_TAG])));
	endproperty
	a_tag_inject: assert property (p_tag_inject) else $error("tag parity stored wrong"); // RL1

	property p_tag_clean;
		@(posedge sys_clk) disable iff (sys_rst)
		(fillValid && !inject_r[BIT_INJECT_TAG]) |=> (entry_r[$past(fillIndex)].tagPar == ^$past(fillTag));
	endproperty
	a_tag_clean: assert property (p_tag_clean) else $error("tag error injected while disabled"); // RL2

	property p_data_inject;
		@(posedge sys_clk) disable iff (sys_rst)
		(fillValid && inject_r[BIT_INJECT_DATA]) |=> (entry_r[$past(fillIndex)].dataPar != ^$past(fillData));
	endproperty
	a_data_inject: assert property (p_data_inject) else $error("data parity not corrupted"); // RL3

	property p_data_clean;
		@(posedge sys_clk) disable iff (sys_rst)
		(fillValid && !inject_r[BIT_INJECT_DATA]) |=> (entry_r[$past(fillIndex)].dataPar == ^$past(fillData));
	endproperty
	a_data_clean: assert property (p_data_clean) else $error("data error injected while disabled"); // RL4

	property p_fault_on_use;
		@(posedge sys_clk) disable iff (sys_rst)
		!lookupValid |=> !faultTag && !faultData;
	endproperty
	a_fault_on_use: assert property (p_fault_on_use) else $error("fault without a lookup"); // RL5

	property p_tag_masks_data;
		@(posedge sys_clk) disable iff (sys_rst)
		faultTag |-> !faultData;
	endproperty
	a_tag_masks_data: assert property (p_tag_masks_data) else $error("data fault reported with tag fault"); // RL6

	property p_syndrome;
		@(posedge sys_clk) disable iff (sys_rst)
		(status_r == 2'h0 && tagBad) |=> (syndrome_r == SYN_TAG) && status_r[BIT_EVT_TAG];
	endproperty
	a_syndrome: assert property (p_syndrome) else $error("tag syndrome not recorded"); // RL9

	property p_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		faultTag && faultIrqEn_r && mask_r[BIT_EVT_TAG] |-> faultIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("fault interrupt missing"); // RL10

	property p_inject_write;
		@(posedge sys_clk) disable iff (sys_rst)
		(wrStrobe && hitInject) |=> inject_r == $past(pwdata[1:0]);
	endproperty
	a_inject_write: assert property (p_inject_write) else $error("injection register not written"); // RL11

	// ----------------------------------------------------------------
	// assertions on lookup results, status and the register port
	// ----------------------------------------------------------------
	// a tag mismatch on use gives a tag fault only, never a hit
	property p_tag_fault;
		@(posedge sys_clk) disable iff (sys_rst)
		(lookupValid && lookEntry.valid && (lookEntry.tagPar != ^lookupTag)) |=> faultTag && !faultData && !lookupHit;
	endproperty
	a_tag_fault: assert property (p_tag_fault) else $error("tag fault not raised on use"); // RL5

	// a data mismatch behind a good tag gives a data fault only
	property p_data_fault;
		@(posedge sys_clk) disable iff (sys_rst)
		(lookupValid && lookEntry.valid && (lookEntry.tagPar == ^lookupTag) && (lookEntry.dataPar != ^lookupData))
			|=> faultData && !faultTag && !lookupHit;
	endproperty
	a_data_fault: assert property (p_data_fault) else $error("data fault not raised on use"); // RL3

	// an entry with both parities right is a clean hit
	property p_clean_hit;
		@(posedge sys_clk) disable iff (sys_rst)
		(lookupValid && lookEntry.valid && (lookEntry.tagPar == ^lookupTag) && (lookEntry.dataPar == ^lookupData))
			|=> lookupHit && !faultTag && !faultData;
	endproperty
	a_clean_hit: assert property (p_clean_hit) else $error("clean entry not reported as hit"); // RL2

	// an empty slot answers nothing, so a reset cache never faults
	property p_invalid_silent;
		@(posedge sys_clk) disable iff (sys_rst)
		(lookupValid && !lookEntry.valid) |=> !lookupHit && !faultTag && !faultData;
	endproperty
	a_invalid_silent: assert property (p_invalid_silent) else $error("lookup of empty entry answered"); // RL5

	// the first data fault into an empty status records the data code
	property p_syndrome_data;
		@(posedge sys_clk) disable iff (sys_rst)
		(status_r == 2'h0 && dataBad) |=> (syndrome_r == SYN_DATA) && status_r[BIT_EVT_DATA];
	endproperty
	a_syndrome_data: assert property (p_syndrome_data) else $error("data syndrome not recorded"); // RL9

	// a tag event bit stays until software writes a one to it
	property p_status_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		(status_r[BIT_EVT_TAG] && !(wrStrobe && hitStatus && pwdata[SYN_LSB+BIT_EVT_TAG])) |=> status_r[BIT_EVT_TAG];
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("tag event bit lost"); // RL9

	// interrupt stays quiet while the fault enable is clear
	property p_irq_off;
		@(posedge sys_clk) disable iff (sys_rst)
		!faultIrqEn_r |=> !faultIrq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt with fault enable clear"); // RL10

	// a pending unmasked event keeps the level up unless software touches it
	property p_irq_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		(faultIrqEn_r && |(status_r & mask_r) && !(wrStrobe && (hitStatus || hitMask || hitControl))) |=> faultIrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped while pending"); // RL10

	// a fill always leaves a valid entry behind
	property p_fill_valid;
		@(posedge sys_clk) disable iff (sys_rst)
		fillValid |=> entry_r[$past(fillIndex)].valid;
	endproperty
	a_fill_valid: assert property (p_fill_valid) else $error("filled entry not valid"); // RL12

	// without a fill the entry at lookupIndex keeps its value, whatever the inject bits do
	property p_entry_kept;
		@(posedge sys_clk) disable iff (sys_rst)
		!fillValid |=> (entry_r[$past(lookupIndex)] == $past(lookEntry));
	endproperty
	a_entry_kept: assert property (p_entry_kept) else $error("resident entry changed without fill"); // RL12

	// the inject bits move only on a register write
	property p_inject_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		!(wrStrobe && hitInject) |=> $stable(inject_r);
	endproperty
	a_inject_hold: assert property (p_inject_hold) else $error("injection bits changed without write"); // RL11

	// an unmapped address is answered with an error, not ignored
	property p_unmapped_err;
		@(posedge sys_clk) disable iff (sys_rst)
		(setupPhase && !hitAny) |=> pready && pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access without error"); // RL11

	// ready is a single cycle, back to back transfers still see it fall
	property p_ready_one;
		@(posedge sys_clk) disable iff (sys_rst)
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready held longer than one cycle"); // RL11

	// error response only comes with ready
	property p_err_with_ready;
		@(posedge sys_clk) disable iff (sys_rst)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error response without ready"); // RL11

	// read data is zero outside the access phase, so stale values never leak
	property p_prdata_idle;
		@(posedge sys_clk) disable iff (sys_rst)
		!pready |-> (prdata == 32'h0);
	endproperty
	a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside access phase"); // RL11
endmodule

//--- tb/tpe_injector_tb_top.sv
// Purpose: self-checking bench for the translation cache parity error injector
// Assumes: zero-wait APB slave, registered fault pulses one cycle after a lookup
// Notes: a small entry count keeps indices colliding so stale parity gets reused
`timescale 1ns/1ps
module tpe_injector_tb_top;
	import tpe_pkg::*;
	localparam int ENT = 4;
	localparam logic [19:0] OFS_HOLE = 20'h08E00;
	logic sysClk, sysRst, psel, penable, pwrite, pready, pslverr;
	logic fillValid, lookupValid, lookupHit, faultTag, faultData, faultIrq;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, fillData, lookupData;
	logic [1:0] fillIndex, lookupIndex;
	logic [19:0] fillTag, lookupTag;
	int errorCnt = 0;
	int cmpCount = 0;
	// ----------------------------------------------------------------
	// reference model state
	// ----------------------------------------------------------------
	logic [1:0] inj = 2'h0, mask = 2'h3, evt = 2'h0;
	logic en = 1'b1;
	logic [7:0] syn = 8'h00;
	bit synKnown = 1'b1;
	bit mVal[ENT], mTagBad[ENT], mDataBad[ENT];
	logic [19:0] mTag[ENT];
	logic [31:0] mData[ENT];
	logic [19:0] adrs[5] = '{OFS_INJECTION, OFS_FAULT_CONTROL, OFS_FAULT_STATUS, OFS_IRQ_MASK, OFS_HOLE};

	tpe_injector #(.ENTRIES(ENT), .TAG_W(20), .DATA_W(32)) i_tpe_injector (.sys_clk(sysClk), .sys_rst(sysRst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fillValid(fillValid), .fillIndex(fillIndex), .fillTag(fillTag),
		.fillData(fillData), .lookupValid(lookupValid), .lookupIndex(lookupIndex), .lookupTag(lookupTag),
		.lookupData(lookupData), .lookupHit(lookupHit), .faultTag(faultTag), .faultData(faultData),
		.faultIrq(faultIrq));

	// free-running clock, 20 ns period
	initial begin
		sysClk = 1'b0;
		forever #10 sysClk = ~sysClk;
	end

	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic cmp1(input logic got, input logic exp, input string what);
		cmpCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmpCount++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic endOfTest();
		if (errorCnt == 0 && cmpCount > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// bus and cache drivers
	// ----------------------------------------------------------------
	// request held from setup until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n = 0;
		@(posedge sysClk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge sysClk);
		penable <= 1'b1;
		do begin
			@(posedge sysClk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic regWr(input logic [19:0] a, input logic [31:0] v);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, v, rd, err);
		cmp1(err, a == OFS_HOLE, "write error response");
		if (a == OFS_INJECTION) inj = v[1:0];
		if (a == OFS_FAULT_CONTROL) en = v[3];
		if (a == OFS_IRQ_MASK) mask = v[1:0];
		if (a == OFS_FAULT_STATUS) begin
			evt = evt & ~v[9:8];
			if (evt == 2'h0) synKnown = 1'b0; // syndrome after a full clear is left open
		end
	endtask

	task automatic regRd(input logic [19:0] a);
		logic [31:0] rd, exp;
		logic err;
		logic [31:0] m = 32'hFFFF_FFFF;
		apb(1'b0, a, 32'h0000_0000, rd, err);
		exp = 32'h0000_0000;
		if (a == OFS_INJECTION) exp = {30'h0, inj};
		if (a == OFS_FAULT_CONTROL) exp = {28'h0, en, 3'h0};
		if (a == OFS_IRQ_MASK) exp = {30'h0, mask};
		if (a == OFS_FAULT_STATUS) exp = {22'h0, evt, syn};
		if (a == OFS_FAULT_STATUS && !synKnown) m = 32'hFFFF_FF00;
		cmp1(err, a == OFS_HOLE, "read error response");
		cmp32(rd & m, exp & m, "register read");
	endtask

	task automatic fill(input int idx);
		@(posedge sysClk);
		fillValid <= 1'b1; fillIndex <= idx[1:0]; fillTag <= 20'($urandom); fillData <= $urandom;
		@(posedge sysClk);
		fillValid <= 1'b0;
		mVal[idx] = 1'b1; mTagBad[idx] = inj[1]; mDataBad[idx] = inj[0];
		mTag[idx] = fillTag; mData[idx] = fillData;
		#1;
		cmp1(faultTag | faultData, 1'b0, "fault on write");
	endtask

	// the bench presents the true tag and data, so only stored parity can fault
	task automatic look(input int idx);
		logic t, d;
		@(posedge sysClk);
		lookupValid <= 1'b1; lookupIndex <= idx[1:0]; lookupTag <= mTag[idx]; lookupData <= mData[idx];
		@(posedge sysClk);
		lookupValid <= 1'b0;
		t = mVal[idx] && mTagBad[idx];
		d = mVal[idx] && !mTagBad[idx] && mDataBad[idx];
		if ((t || d) && evt == 2'h0) begin
			syn = t ? 8'h07 : 8'h08;
			synKnown = 1'b1;
		end
		evt = evt | {d, t};
		#1;
		cmp1(faultTag, t, "tag fault");
		cmp1(faultData, d, "data fault");
		cmp1(lookupHit, mVal[idx] && !t && !d, "clean hit");
		cmp1(faultIrq, en && ((evt & mask) != 2'h0), "interrupt level");
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		sysRst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 20'h00000; pwdata = 32'h0000_0000;
		fillValid = 1'b0; fillIndex = 2'h0; fillTag = 20'h00000; fillData = 32'h0000_0000;
		lookupValid = 1'b0; lookupIndex = 2'h0; lookupTag = 20'h00000; lookupData = 32'h0000_0000;
		foreach (mVal[k]) begin
			mVal[k] = 1'b0; mTag[k] = 20'h00000; mData[k] = 32'h0000_0000;
		end
		void'($urandom(32'hE09241E2));
		repeat (8) @(posedge sysClk);
		sysRst <= 1'b0;
		for (int k = 0; k < 5; k++) regRd(adrs[k]);
		// every injection code once, then every entry used with injection off
		for (int k = 0; k < ENT; k++) begin
			regWr(OFS_INJECTION, k);
			fill(k);
		end
		regWr(OFS_INJECTION, 32'h0000_0000);
		for (int k = 0; k < ENT; k++) look(k);
		regRd(OFS_FAULT_STATUS);
		for (int n = 0; n < 400; n++) begin
			case ($urandom_range(6))
				0: regWr(OFS_INJECTION, $urandom & 32'h3);
				1, 2: fill($urandom_range(ENT - 1));
				3, 4: look($urandom_range(ENT - 1));
				5: regRd(adrs[$urandom_range(4)]);
				default: regWr(adrs[1 + $urandom_range(3)], $urandom);
			endcase
		end
		endOfTest();
	end

	// cuts a hang short well beyond the thousand or so cycles the run needs
	initial begin
		repeat (30000) @(posedge sysClk);
		errorCnt++;
		endOfTest();
	end
endmodule
